// ===== include/flvic_pkg.sv
// constants and carrier types of the four-level vectored interrupt controller
`default_nettype none
package flvic_pkg;
  localparam int FLVIC_NSRC = 7;
  localparam int FLVIC_AW = 4;

  // register word indices on the plain register port
  localparam logic [3:0] FLVIC_OFS_IEN = 4'h0;
  localparam logic [3:0] FLVIC_OFS_PRIO_LO = 4'h1;
  localparam logic [3:0] FLVIC_OFS_PRIO_HI = 4'h2;
  localparam logic [3:0] FLVIC_OFS_TMRCTL = 4'h3;
  localparam logic [3:0] FLVIC_OFS_PERFLAG = 4'h4;
  localparam logic [3:0] FLVIC_OFS_ACTIVE = 4'h5;
  localparam logic [3:0] FLVIC_OFS_EVT_STAT = 4'h6;
  localparam logic [3:0] FLVIC_OFS_EVT_CLR = 4'h7;
  localparam logic [3:0] FLVIC_OFS_EVT_EN = 4'h8;

  // interrupt_enable fields; bits 6..0 follow the source index
  localparam int FLVIC_IEN_GLOBAL = 7;

  // timer/external control register fields
  localparam int FLVIC_TC_EXT0_EDGE = 0;
  localparam int FLVIC_TC_EXT0_FLAG = 1;
  localparam int FLVIC_TC_EXT1_EDGE = 2;
  localparam int FLVIC_TC_EXT1_FLAG = 3;
  localparam int FLVIC_TC_SPLIT = 4;
  localparam int FLVIC_TC_T0_OVF = 5;
  localparam int FLVIC_TC_T1_RUN = 6;
  localparam int FLVIC_TC_T1_OVF = 7;

  // peripheral flag register fields
  localparam int FLVIC_PF_UART_RX = 0;
  localparam int FLVIC_PF_UART_TX = 1;
  localparam int FLVIC_PF_SPI = 2;
  localparam int FLVIC_PF_ADC = 3;
  localparam int FLVIC_PF_CNTARR = 4;
  localparam int FLVIC_PF_LOWV = 5;

  // controller event bits
  localparam int FLVIC_EV_GRANT = 0;
  localparam int FLVIC_EV_NEST = 1;
  localparam int FLVIC_EV_SPUR_RET = 2;

  // source indices, also the polling order
  localparam logic [2:0] FLVIC_SRC_EXT0 = 3'h0;
  localparam logic [2:0] FLVIC_SRC_T0 = 3'h1;
  localparam logic [2:0] FLVIC_SRC_EXT1 = 3'h2;
  localparam logic [2:0] FLVIC_SRC_T1 = 3'h3;
  localparam logic [2:0] FLVIC_SRC_UART = 3'h4;
  localparam logic [2:0] FLVIC_SRC_SPI_ADC = 3'h5;
  localparam logic [2:0] FLVIC_SRC_CNT_LOWV = 3'h6;

  // vector = base + 8 * source index
  localparam logic [7:0] FLVIC_VEC_BASE = 8'h03;
  localparam logic [7:0] FLVIC_VEC_LAST = 8'h33;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } flvic_bus_t;

  typedef struct packed {
    logic uartRx;
    logic uartTx;
    logic spi;
    logic adc;
    logic cntArr;
    logic lowV;
  } flvic_periph_t;

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] prioLo;
    logic [7:0] prioHi;
    logic [1:0] extEdge;
    logic [1:0] extFlag;
    logic [1:0] tOvf;
    logic t1Run;
    logic split;
    logic [5:0] perFlag;
    logic [3:0] active;
    logic [2:0] evtStat;
    logic [2:0] evtEn;
    logic [1:0][1:0] pinSync;
    logic [1:0] pinPrev;
    logic irqReq;
    logic [7:0] vec;
    logic [2:0] src;
    logic [1:0] lvl;
    logic [7:0] rdData;
  } flvic_state_t;

  // pins idle high; synchronisers start there so reset shows no false level
  localparam logic [1:0] FLVIC_PIN_IDLE = 2'h3;
  localparam flvic_state_t FLVIC_RST_STATE = '{
    pinSync: {FLVIC_PIN_IDLE, FLVIC_PIN_IDLE},
    pinPrev: FLVIC_PIN_IDLE,
    default: '0
  };
endpackage : flvic_pkg
`default_nettype wire

// ===== hw/flvic_ctrl.sv
// four-level vectored interrupt controller with register port and cpu handshake
// How it works
// - seven sources, own enables, global enable gate
// - level from high and low priority bits
// - lower level never preempts higher routine
// - higher level wins among simultaneous requests
// - same level resolved by fixed polling order
// - vectors 03h through 33h, step eight
// - external flags level or edge by select
// - vectoring clears external flag only in edge
// - vectoring clears timer overflow flag
// - uart request is rx or tx, kept
// - serial/conv source ored, never hardware cleared
// - counter/low-voltage source ored, never hardware cleared
// - software writes flags like hardware events, except external flags in level mode
// - all enables zero after reset
// - split timer0 high byte uses timer1 bits
// - select 0 low level, 1 falling edge
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module flvic_ctrl
  import flvic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire flvic_bus_t busReq,
  output logic [7:0] busRdData,
  // external interrupt pins, asynchronous
  input wire logic ext0Pin,
  input wire logic ext1Pin,
  // timer overflow pulses
  input wire logic timer0Ovf,
  input wire logic timer1Ovf,
  input wire logic timer0HighOvf,
  // peripheral request pulses
  input wire flvic_periph_t periphSet,
  // cpu vector handshake
  input wire logic isrEnter,
  input wire logic isrReturn,
  output logic cpuIrqReq,
  output logic [7:0] cpuIrqVector,
  // timer run controls
  output logic timer1RunOut,
  output logic timer0HighRunOut,
  output logic timer0SplitMode,
  // controller event interrupt
  output logic sysIrq
);

  flvic_state_t st_ff;
  flvic_state_t nxt_st;

  logic [1:0] srcLvl [FLVIC_NSRC];
  logic [FLVIC_NSRC-1:0] req;
  logic [FLVIC_NSRC-1:0] pend;
  logic [1:0] extLvl;
  logic [1:0] extFall;
  logic [1:0] pinIn;
  logic [1:0] tSet;
  logic [1:0] activeTop;
  logic anyActive;
  logic found;
  logic [2:0] bestSrc;
  logic [1:0] bestLvl;
  logic allow;
  logic taken;
  logic [7:0] tmrCtlRd;
  logic [3:0] actNext;
  logic [1:0] actNextTop;

  assign pinIn = {ext1Pin, ext0Pin};
  assign taken = isrEnter && st_ff.irqReq;

  // split mode routes high byte overflow
  assign tSet[0] = timer0Ovf;
  assign tSet[1] = st_ff.split ? timer0HighOvf : timer1Ovf;

  genvar g;
  generate
    for (g = 0; g < FLVIC_NSRC; g++) begin : gSrc
      assign srcLvl[g] = {st_ff.prioHi[g], st_ff.prioLo[g]};
    end
    for (g = 0; g < 2; g++) begin : gExt
      // second sync stage is the first one logic may read
      assign extLvl[g] = st_ff.pinSync[g][1];
      assign extFall[g] = st_ff.pinPrev[g] && !st_ff.pinSync[g][1];
    end
  endgenerate

  // uart request is rx or tx
  // counter array and low voltage ored
  assign req = {
    st_ff.perFlag[FLVIC_PF_CNTARR] | st_ff.perFlag[FLVIC_PF_LOWV],
    st_ff.perFlag[FLVIC_PF_SPI] | st_ff.perFlag[FLVIC_PF_ADC],
    st_ff.perFlag[FLVIC_PF_UART_RX] | st_ff.perFlag[FLVIC_PF_UART_TX],
    st_ff.tOvf[1], st_ff.extFlag[1], st_ff.tOvf[0], st_ff.extFlag[0]};

  assign pend = req & st_ff.ien[FLVIC_NSRC-1:0] & {FLVIC_NSRC{st_ff.ien[FLVIC_IEN_GLOBAL]}};

  always_comb begin
    anyActive = |st_ff.active;
    activeTop = 2'b00;
    for (int l = 0; l < 4; l++) begin
      if (st_ff.active[l]) begin
        activeTop = 2'(l);
      end
    end
  end

  // active levels once this cycle's return and entry land; offering
  // against these keeps a just-taken source from being offered again
  always_comb begin
    actNext = st_ff.active;
    if (isrReturn && anyActive) begin
      actNext[activeTop] = 1'b0;
    end
    if (taken) begin
      actNext[st_ff.lvl] = 1'b1;
    end
    actNextTop = 2'b00;
    for (int l = 0; l < 4; l++) begin
      if (actNext[l]) begin
        actNextTop = 2'(l);
      end
    end
  end

  // lowest index wins within a level
  always_comb begin
    found = 1'b0;
    bestSrc = 3'h0;
    bestLvl = 2'b00;
    for (int l = 3; l >= 0; l--) begin
      for (int i = 0; i < FLVIC_NSRC; i++) begin
        if (!found && pend[i] && srcLvl[i] == 2'(l)) begin
          found = 1'b1;
          bestSrc = 3'(i);
          bestLvl = 2'(l);
        end
      end
    end
  end

  // only strictly higher than running level
  assign allow = !(|actNext) || (bestLvl > actNextTop);

  assign tmrCtlRd = {st_ff.tOvf[1], st_ff.t1Run, st_ff.tOvf[0], st_ff.split,
                     st_ff.extFlag[1], st_ff.extEdge[1], st_ff.extFlag[0], st_ff.extEdge[0]};

  always_comb begin
    nxt_st = st_ff;

    // register writes
    if (busReq.wr) begin
      case (busReq.addr)
        FLVIC_OFS_IEN: nxt_st.ien = busReq.wdata;
        FLVIC_OFS_PRIO_LO: nxt_st.prioLo = {1'b0, busReq.wdata[6:0]};
        FLVIC_OFS_PRIO_HI: nxt_st.prioHi = {1'b0, busReq.wdata[6:0]};
        FLVIC_OFS_TMRCTL: begin
          nxt_st.extEdge[0] = busReq.wdata[FLVIC_TC_EXT0_EDGE];
          nxt_st.extFlag[0] = busReq.wdata[FLVIC_TC_EXT0_FLAG];
          nxt_st.extEdge[1] = busReq.wdata[FLVIC_TC_EXT1_EDGE];
          nxt_st.extFlag[1] = busReq.wdata[FLVIC_TC_EXT1_FLAG];
          nxt_st.split = busReq.wdata[FLVIC_TC_SPLIT];
          nxt_st.tOvf[0] = busReq.wdata[FLVIC_TC_T0_OVF];
          nxt_st.t1Run = busReq.wdata[FLVIC_TC_T1_RUN];
          nxt_st.tOvf[1] = busReq.wdata[FLVIC_TC_T1_OVF];
        end
        FLVIC_OFS_PERFLAG: nxt_st.perFlag = busReq.wdata[5:0];
        FLVIC_OFS_EVT_CLR: nxt_st.evtStat = st_ff.evtStat & ~busReq.wdata[2:0];
        FLVIC_OFS_EVT_EN: nxt_st.evtEn = busReq.wdata[2:0];
        default: ;
      endcase
    end

    // read data stands for one cycle only
    nxt_st.rdData = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        FLVIC_OFS_IEN: nxt_st.rdData = st_ff.ien;
        FLVIC_OFS_PRIO_LO: nxt_st.rdData = st_ff.prioLo;
        FLVIC_OFS_PRIO_HI: nxt_st.rdData = st_ff.prioHi;
        FLVIC_OFS_TMRCTL: nxt_st.rdData = tmrCtlRd;
        FLVIC_OFS_PERFLAG: nxt_st.rdData = {2'b00, st_ff.perFlag};
        FLVIC_OFS_ACTIVE: nxt_st.rdData = {4'h0, st_ff.active};
        FLVIC_OFS_EVT_STAT: nxt_st.rdData = {5'h00, st_ff.evtStat};
        FLVIC_OFS_EVT_EN: nxt_st.rdData = {5'h00, st_ff.evtEn};
        default: nxt_st.rdData = 8'h00;
      endcase
    end

    // return pops the highest running level, entry pushes the taken one
    nxt_st.active = actNext;
    if (isrReturn && !anyActive) begin
      nxt_st.evtStat[FLVIC_EV_SPUR_RET] = 1'b1;
    end

    // entry pulse takes the offered vector
    if (taken) begin
      nxt_st.evtStat[FLVIC_EV_GRANT] = 1'b1;
      if (anyActive) begin
        nxt_st.evtStat[FLVIC_EV_NEST] = 1'b1;
      end
      case (st_ff.src)
        // edge mode flag cleared on entry
        FLVIC_SRC_EXT0: if (st_ff.extEdge[0]) nxt_st.extFlag[0] = 1'b0;
        FLVIC_SRC_EXT1: if (st_ff.extEdge[1]) nxt_st.extFlag[1] = 1'b0;
        FLVIC_SRC_T0: nxt_st.tOvf[0] = 1'b0;
        FLVIC_SRC_T1: nxt_st.tOvf[1] = 1'b0;
        // shared sources leave their flags to software
        default: ;
      endcase
    end

    // hardware sets last so they win over any clear
    for (int e = 0; e < 2; e++) begin
      nxt_st.pinSync[e] = {st_ff.pinSync[e][0], pinIn[e]};
      nxt_st.pinPrev[e] = st_ff.pinSync[e][1];
      // flag per pin, mode from select bit
      // select 1 falling edge, 0 low level
      if (nxt_st.extEdge[e]) begin
        if (extFall[e]) begin
          nxt_st.extFlag[e] = 1'b1;
        end
      end else begin
        nxt_st.extFlag[e] = !extLvl[e];
      end
      if (tSet[e]) begin
        nxt_st.tOvf[e] = 1'b1;
      end
    end
    nxt_st.perFlag = nxt_st.perFlag | {periphSet.lowV, periphSet.cntArr, periphSet.adc,
                                       periphSet.spi, periphSet.uartTx, periphSet.uartRx};

    // offer the winner; a source just taken is masked by its active level
    nxt_st.irqReq = found && allow;
    nxt_st.src = bestSrc;
    nxt_st.lvl = bestLvl;
    // vector is base plus eight per source
    nxt_st.vec = FLVIC_VEC_BASE + {2'b00, bestSrc, 3'b000};
  end

  // every enable and priority clears at reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= FLVIC_RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busRdData = st_ff.rdData;
  assign cpuIrqReq = st_ff.irqReq;
  assign cpuIrqVector = st_ff.vec;
  // timer1 run bit drives the high byte in split mode
  assign timer1RunOut = st_ff.t1Run && !st_ff.split;
  assign timer0HighRunOut = st_ff.t1Run && st_ff.split;
  assign timer0SplitMode = st_ff.split;
  assign sysIrq = |(st_ff.evtStat & st_ff.evtEn);

  default clocking cbMain @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  glob_gate_a: assert property (
    !st_ff.ien[FLVIC_IEN_GLOBAL] |=> !cpuIrqReq)
    else $error("request offered with global enable off");

  prio_form_a: assert property (
    cpuIrqReq |-> st_ff.lvl == {$past(st_ff.prioHi[bestSrc]), $past(st_ff.prioLo[bestSrc])})
    else $error("offered level does not match priority bits");

  no_preempt_a: assert property (
    cpuIrqReq && anyActive |-> st_ff.lvl > activeTop)
    else $error("request offered at or below running level");

  same_level_a: assert property (
    cpuIrqReq |-> !st_ff.active[st_ff.lvl])
    else $error("request offered at a level already in service");

  top_pick_a: assert property (
    pend[0] && srcLvl[0] == 2'b11 && !anyActive && !isrEnter
    |=> cpuIrqReq && cpuIrqVector == FLVIC_VEC_BASE)
    else $error("top level external 0 not offered first");

  vec_range_a: assert property (
    cpuIrqReq |-> cpuIrqVector[2:0] == FLVIC_VEC_BASE[2:0] && cpuIrqVector <= FLVIC_VEC_LAST)
    else $error("vector outside the table");

  edge_clear_a: assert property (
    taken && st_ff.src == FLVIC_SRC_EXT0 && st_ff.extEdge[0] && !extFall[0] && !busReq.wr
    |=> !st_ff.extFlag[0])
    else $error("edge flag not cleared on entry");

  level_follow_a: assert property (
    !st_ff.extEdge[0] |-> st_ff.extFlag[0] == !st_ff.pinPrev[0])
    else $error("level mode flag does not follow pin");

  timer_clear_a: assert property (
    taken && st_ff.src == FLVIC_SRC_T0 && !timer0Ovf && !busReq.wr |=> !st_ff.tOvf[0])
    else $error("timer 0 flag not cleared on entry");

  shared_keep_a: assert property (
    taken && st_ff.src >= FLVIC_SRC_UART && !busReq.wr
    |=> ($past(st_ff.perFlag) & ~st_ff.perFlag) == 6'h00)
    else $error("shared source flag cleared by hardware");

  split_route_a: assert property (
    st_ff.split && timer0HighOvf |=> st_ff.tOvf[1] ##1 1'b1)
    else $error("high byte overflow did not set timer 1 flag");

  read_once_a: assert property (
    !busReq.rd |=> busRdData == 8'h00)
    else $error("read data outside the answer cycle");

  src_mask_a: assert property (
    !st_ff.ien[FLVIC_SRC_T0] |=> !(cpuIrqReq && st_ff.src == FLVIC_SRC_T0))
    else $error("disabled timer 0 source offered");

  top_level_a: assert property (
    pend[FLVIC_SRC_CNT_LOWV] && srcLvl[FLVIC_SRC_CNT_LOWV] == 2'b11 && !anyActive && !isrEnter
    |=> cpuIrqReq && st_ff.lvl == 2'b11)
    else $error("top level request lost to a lower level");

  poll_order_a: assert property (
    pend[FLVIC_SRC_T0] && srcLvl[FLVIC_SRC_T0] == srcLvl[FLVIC_SRC_EXT1]
    |=> !(cpuIrqReq && st_ff.src == FLVIC_SRC_EXT1))
    else $error("external 1 offered ahead of timer 0");

  last_vec_a: assert property (
    cpuIrqReq && st_ff.src == FLVIC_SRC_CNT_LOWV |-> cpuIrqVector == FLVIC_VEC_LAST)
    else $error("last source vector wrong");

  edge_set_a: assert property (
    st_ff.extEdge[1] && extFall[1] |=> st_ff.extFlag[1])
    else $error("falling edge did not set external 1 flag");

  edge1_clear_a: assert property (
    taken && st_ff.src == FLVIC_SRC_EXT1 && st_ff.extEdge[1] && !extFall[1] && !busReq.wr
    |=> !st_ff.extFlag[1])
    else $error("edge flag 1 not cleared on entry");

  level_keep_a: assert property (
    taken && st_ff.src == FLVIC_SRC_EXT0 && !st_ff.extEdge[0] && !extLvl[0] && !busReq.wr
    |=> st_ff.extFlag[0])
    else $error("level mode flag cleared on entry");

  timer1_clear_a: assert property (
    taken && st_ff.src == FLVIC_SRC_T1 && !tSet[1] && !busReq.wr |=> !st_ff.tOvf[1])
    else $error("timer 1 flag not cleared on entry");

  uart_or_a: assert property (
    st_ff.perFlag[FLVIC_PF_UART_TX] && st_ff.ien[FLVIC_SRC_UART] && st_ff.ien[FLVIC_IEN_GLOBAL]
    |-> pend[FLVIC_SRC_UART])
    else $error("uart transmit flag raises no request");

  conv_keep_a: assert property (
    taken && st_ff.src == FLVIC_SRC_SPI_ADC && st_ff.perFlag[FLVIC_PF_ADC] && !busReq.wr
    |=> st_ff.perFlag[FLVIC_PF_ADC])
    else $error("conversion flag cleared by entry");

  lowv_keep_a: assert property (
    taken && st_ff.src == FLVIC_SRC_CNT_LOWV && st_ff.perFlag[FLVIC_PF_LOWV] && !busReq.wr
    |=> st_ff.perFlag[FLVIC_PF_LOWV])
    else $error("low voltage flag cleared by entry");

  sw_write_a: assert property (
    busReq.wr && busReq.addr == FLVIC_OFS_PERFLAG && periphSet == '0
    |=> st_ff.perFlag == $past(busReq.wdata[5:0]))
    else $error("software write did not land in peripheral flags");

  level1_follow_a: assert property (
    !st_ff.extEdge[1] |-> st_ff.extFlag[1] == !st_ff.pinPrev[1])
    else $error("level mode flag 1 does not follow pin");

  high_ignore_a: assert property (
    !st_ff.split && timer0HighOvf && !timer1Ovf && !st_ff.tOvf[1] && !busReq.wr
    |=> !st_ff.tOvf[1])
    else $error("high byte overflow set timer 1 flag outside split mode");

endmodule : flvic_ctrl
`default_nettype wire

// ===== verif/flvic_cpu_model.sv
// processor core model: takes offered vectors and returns on command
`timescale 1ns/1ps
`default_nettype none
module flvic_cpu_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // vector handshake
  input wire logic cpuIrqReq,
  output logic isrEnter,
  output logic isrReturn,
  // bench commands
  input wire logic takeCmd,
  input wire logic retCmd,
  input wire logic [3:0] takeDelay
);
  logic armed;
  logic [3:0] waitCnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
      waitCnt <= 4'h0;
      isrEnter <= 1'b0;
      isrReturn <= 1'b0;
    end else begin
      isrEnter <= 1'b0;
      isrReturn <= retCmd;
      if (takeCmd) begin
        armed <= 1'b1;
        waitCnt <= 4'h0;
      end else if (armed && cpuIrqReq) begin
        // slow answers hold off entry for takeDelay cycles
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == takeDelay) begin
          isrEnter <= 1'b1;
          armed <= 1'b0;
        end
      end
    end
  end
endmodule : flvic_cpu_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the interrupt controller against a queue model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    failCount++; \
    $display("unexpected at %0t: got %h, expected %h", $time, (a), (e)); \
  end \
end
module tb import flvic_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  flvic_bus_t busReq = '0;
  flvic_periph_t periphSet = '0;
  logic ext0Pin = 1'b1;
  logic ext1Pin = 1'b1;
  logic timer0Ovf = 1'b0;
  logic timer1Ovf = 1'b0;
  logic timer0HighOvf = 1'b0;
  logic takeCmd = 1'b0;
  logic retCmd = 1'b0;
  logic [3:0] takeDelay = 4'h0;
  logic isrEnter, isrReturn, cpuIrqReq, timer1RunOut, timer0HighRunOut, timer0SplitMode, sysIrq;
  logic [7:0] busRdData, cpuIrqVector, ien, plo, phi;
  logic [6:0] fl;
  logic [5:0] pf;
  logic [31:0] r;
  int act[$];
  int e, nTake, failCount, compares;

  flvic_ctrl u_dut (.sys_clk, .rst_b, .busReq, .busRdData, .ext0Pin, .ext1Pin, .timer0Ovf,
    .timer1Ovf, .timer0HighOvf, .periphSet, .isrEnter, .isrReturn, .cpuIrqReq, .cpuIrqVector,
    .timer1RunOut, .timer0HighRunOut, .timer0SplitMode, .sysIrq);
  flvic_cpu_model u_cpu (.sys_clk, .rst_b, .cpuIrqReq, .isrEnter, .isrReturn, .takeCmd,
    .retCmd, .takeDelay);

  always #25 sys_clk = ~sys_clk;

  function automatic int lvlOf(int s);
    return 2 * int'(phi[s]) + int'(plo[s]);
  endfunction : lvlOf

  function automatic int expVec();
    int best;
    best = -1;
    for (int s = 6; s >= 0; s--) begin
      if (ien[7] && ien[s] && fl[s] && (best < 0 || lvlOf(s) >= lvlOf(best))) best = s;
    end
    // same or lower level than the running routine waits
    if (best >= 0 && act.size() > 0 && lvlOf(best) <= act[$]) best = -1;
    return best;
  endfunction : expVec

  function automatic logic [7:0] tc();
    return {fl[3], 1'b0, fl[1], 1'b0, fl[2], 1'b1, fl[0], 1'b1};
  endfunction : tc

  task automatic results();
    $display("counts: %0d compares, %0d mismatches", compares, failCount);
    if (failCount == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    busReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    busReq <= '0;
    @(posedge sys_clk);
    `CHK(busRdData, x)
  endtask : rdc

  task automatic chkIrq();
    repeat (3) @(posedge sys_clk);
    e = expVec();
    `CHK(cpuIrqReq, 1'(e >= 0))
    if (e >= 0) `CHK(cpuIrqVector, 8'(8'h03 + 8 * e))
  endtask : chkIrq

  task automatic take();
    int n;
    n = 0;
    @(posedge sys_clk);
    takeCmd <= 1'b1;
    takeDelay <= 4'($urandom_range(5));
    @(posedge sys_clk);
    takeCmd <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (isrEnter !== 1'b1 && n < 40);
    if (n >= 40) begin
      failCount++;
      results();
    end else begin
      act.push_back(lvlOf(e));
      if (e < 4) fl[e] = 1'b0;
      nTake++;
    end
  endtask : take

  task automatic ret();
    @(posedge sys_clk);
    retCmd <= 1'b1;
    @(posedge sys_clk);
    retCmd <= 1'b0;
    if (act.size() > 0) void'(act.pop_back());
  endtask : ret

  initial begin
    void'($urandom(32'hdb23));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(FLVIC_OFS_IEN, 8'h00);
    rdc(FLVIC_OFS_PRIO_LO, 8'h00);
    rdc(FLVIC_OFS_PRIO_HI, 8'h00);
    rdc(4'hf, 8'h00);
    $display("reset test done");
    wr(FLVIC_OFS_EVT_EN, 8'h05);
    for (int it = 0; it < 60; it++) begin
      r = $urandom;
      fl = r[6:0];
      pf = {fl[6] & ~r[9], fl[6] & r[9], fl[5] & ~r[8], fl[5] & r[8], fl[4] & ~r[7], fl[4] & r[7]};
      ien = {r[24] | r[25], r[22:16]};
      plo = 8'($urandom) & 8'h7f;
      phi = 8'($urandom) & 8'h7f;
      wr(FLVIC_OFS_IEN, ien);
      wr(FLVIC_OFS_PRIO_LO, plo);
      wr(FLVIC_OFS_PRIO_HI, phi);
      wr(FLVIC_OFS_TMRCTL, tc());
      wr(FLVIC_OFS_PERFLAG, {2'b00, pf});
      chkIrq();
      if (e >= 0) take();
      chkIrq();
      rdc(FLVIC_OFS_TMRCTL, tc());
      rdc(FLVIC_OFS_PERFLAG, {2'b00, pf});
      if (r[31] && act.size() > 0) ret();
      chkIrq();
    end
    $display("arbitration test done");
    `CHK(sysIrq, 1'(nTake > 0))
    wr(FLVIC_OFS_EVT_CLR, 8'h07);
    rdc(FLVIC_OFS_EVT_STAT, 8'h00);
    while (act.size() > 0) ret();
    ret();
    rdc(FLVIC_OFS_EVT_STAT, 8'h04);
    `CHK(sysIrq, 1'b1)
    wr(FLVIC_OFS_EVT_EN, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(sysIrq, 1'b0)
    $display("event test done");
    wr(FLVIC_OFS_IEN, 8'h85);
    wr(FLVIC_OFS_TMRCTL, 8'h04);
    ext0Pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rdc(FLVIC_OFS_TMRCTL, 8'h06);
    `CHK(cpuIrqVector, 8'h03)
    e = 0;
    take();
    rdc(FLVIC_OFS_TMRCTL, 8'h06);
    ret();
    ext0Pin <= 1'b1;
    ext1Pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ext1Pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rdc(FLVIC_OFS_TMRCTL, 8'h0c);
    `CHK(cpuIrqVector, 8'h13)
    e = 2;
    take();
    rdc(FLVIC_OFS_TMRCTL, 8'h04);
    ret();
    $display("external pin test done");
    wr(FLVIC_OFS_TMRCTL, 8'h54);
    timer1Ovf <= 1'b1;
    @(posedge sys_clk);
    timer1Ovf <= 1'b0;
    rdc(FLVIC_OFS_TMRCTL, 8'h54);
    `CHK(timer0HighRunOut, 1'b1)
    `CHK(timer0SplitMode, 1'b1)
    `CHK(timer1RunOut, 1'b0)
    timer0HighOvf <= 1'b1;
    timer0Ovf <= 1'b1;
    periphSet <= '1;
    @(posedge sys_clk);
    timer0HighOvf <= 1'b0;
    timer0Ovf <= 1'b0;
    periphSet <= '0;
    rdc(FLVIC_OFS_TMRCTL, 8'hf4);
    rdc(FLVIC_OFS_PERFLAG, 8'h3f);
    wr(FLVIC_OFS_TMRCTL, 8'h40);
    @(posedge sys_clk);
    `CHK(timer1RunOut, 1'b1)
    `CHK(timer0HighRunOut, 1'b0)
    $display("split timer test done");
    results();
  end
endmodule : tb
`default_nettype wire
